// [rtl/brw_pkg.sv]
/*
 * brw_pkg: offsets, reset values, field positions and carrier types
 * of the bridge window and control register bank.
 * assumes a classic wishbone slave with byte addresses on adr.
 */
`default_nettype none
package brw_pkg;
    // register byte offsets
    localparam logic [7:0] BRW_OFF_PF_BASE_HI = 8'h28;
    localparam logic [7:0] BRW_OFF_PF_LIMIT_HI = 8'h2c;
    localparam logic [7:0] BRW_OFF_IO_HI = 8'h30;
    localparam logic [7:0] BRW_OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] BRW_OFF_INT_CTRL = 8'h3c;
    // values after reset
    localparam logic [31:0] BRW_RST_PF_HI = 32'h0000_0000;
    localparam logic [15:0] BRW_RST_IO_HI = 16'h0000;
    localparam logic [7:0] BRW_RST_INT_LINE = 8'h00;
    localparam logic [7:0] BRW_RST_INT_PIN = 8'h00;
    localparam logic [7:0] BRW_CAP_PTR = 8'h40;
    // forwarding control bit positions within the 0x3c word
    localparam int BRW_BC_POISON = 16;
    localparam int BRW_BC_ERR_FWD = 17;
    localparam int BRW_BC_ALIAS = 18;
    localparam int BRW_BC_DISP = 19;
    localparam int BRW_BC_DISP16 = 20;
    localparam int BRW_BC_SBR = 22;
    // writable forwarding control bits 16..22, 21 kept at zero
    localparam logic [15:0] BRW_BC_WMASK = 16'h005f;
    localparam logic [15:0] BRW_RST_BC = 16'h0000;
    // display memory range and display i/o ranges (low ten bits)
    localparam logic [63:0] BRW_DISP_MEM_LO = 64'h0000_0000_000a_0000;
    localparam logic [63:0] BRW_DISP_MEM_HI = 64'h0000_0000_000b_ffff;
    localparam logic [9:0] BRW_DISP_IO_A_LO = 10'h3b0;
    localparam logic [9:0] BRW_DISP_IO_A_HI = 10'h3bb;
    localparam logic [9:0] BRW_DISP_IO_B_LO = 10'h3c0;
    localparam logic [9:0] BRW_DISP_IO_B_HI = 10'h3df;
    // implied low bits of the prefetchable window bounds
    localparam logic [19:0] BRW_PF_LO_FILL = 20'h00000;
    localparam logic [19:0] BRW_PF_HI_FILL = 20'hfffff;
    // implied low bits of the i/o window bounds
    localparam logic [11:0] BRW_IO_LO_FILL = 12'h000;
    localparam logic [11:0] BRW_IO_HI_FILL = 12'hfff;

    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } brw_wb_req_t;
    // memory request address to classify
    typedef struct packed {
        logic valid;
        logic [63:0] addr;
    } brw_mem_query_t;
    // i/o request address to classify
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } brw_io_query_t;
    // error message seen on the secondary side
    typedef struct packed {
        logic valid;
        logic [1:0] kind;
    } brw_err_msg_t;
    // registered forwarding decisions
    typedef struct packed {
        logic mem_valid;
        logic mem_pf_hit;
        logic mem_disp_hit;
        logic io_valid;
        logic io_fwd_down;
        logic io_fwd_up;
        logic io_disp_hit;
    } brw_route_t;
endpackage
`default_nettype wire

// [rtl/brw_regs.sv]
/*
 * brw_regs: upper window bounds, capability pointer, interrupt fields
 * and forwarding control of one switch port, plus the forwarding
 * decisions and port reset that these registers steer.
 * assumes one 100 MHz clock, classic wishbone master, and lower window
 * bits supplied by the neighbouring register bank on the same clock.
 */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module brw_regs #(
    parameter bit IS_UPSTREAM = 1'b0, // port sits upstream
    parameter int NUM_DS_PORTS = 3 // downstream ports reset by upstream
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire brw_pkg::brw_wb_req_t wb_req,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic cfg_load_valid,
    input wire logic [7:0] cfg_load_int_pin,
    input wire logic [11:0] pf_base_lo,
    input wire logic [11:0] pf_limit_lo,
    input wire logic [3:0] io_base_lo,
    input wire logic [3:0] io_limit_lo,
    input wire brw_pkg::brw_mem_query_t mem_query,
    input wire brw_pkg::brw_io_query_t io_query,
    output brw_pkg::brw_route_t route,
    input wire logic poison_seen,
    output logic poison_report,
    input wire brw_pkg::brw_err_msg_t err_in,
    output brw_pkg::brw_err_msg_t err_out,
    output logic [NUM_DS_PORTS-1:0] port_rst_b
);
    import brw_pkg::*;

    // merge a write into a word under byte enables
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // inclusive window compare on both bounds
    function automatic logic in_window(
        input logic [63:0] addr,
        input logic [63:0] lo,
        input logic [63:0] hi
    );
        return (addr >= lo) && (addr <= hi);
    endfunction

    // display i/o decode, 10 or 16 bits wide
    function automatic logic disp_io(
        input logic [31:0] addr,
        input logic wide
    );
        logic low_hit;
        logic upper_ok;
        low_hit = ((addr[9:0] >= BRW_DISP_IO_A_LO) && (addr[9:0] <= BRW_DISP_IO_A_HI))
            || ((addr[9:0] >= BRW_DISP_IO_B_LO) && (addr[9:0] <= BRW_DISP_IO_B_HI));
        // wide decode also checks bits 15..10
        upper_ok = wide ? (addr[15:10] == 6'h00) : 1'b1;
        // only the first 64KB of i/o space
        return low_hit && upper_ok && (addr[31:16] == 16'h0000);
    endfunction

    // register state
    logic [31:0] pf_base_hi_q; // prefetch base bits 63..32
    logic [31:0] pf_limit_hi_q; // prefetch limit bits 63..32
    logic [15:0] io_base_hi_q; // io base bits 31..16
    logic [15:0] io_limit_hi_q; // io limit bits 31..16
    logic [7:0] int_line_q; // interrupt routing line
    logic [7:0] int_pin_q; // interrupt wire select
    logic [15:0] bc_q; // forwarding control, word bits 31..16
    logic ack_q; // bus answer
    logic [31:0] dat_r_q; // read data
    logic req_new; // fresh request this cycle
    logic wr_go; // write commits at this edge
    logic [31:0] rd_word; // word selected for read

    assign req_new = wb_req.cyc && wb_req.stb && !ack_q;
    assign wr_go = req_new && wb_req.we;

    // single wait cycle answer; ack drops after one cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_new;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_req.adr)
            BRW_OFF_PF_BASE_HI: rd_word = pf_base_hi_q;
            BRW_OFF_PF_LIMIT_HI: rd_word = pf_limit_hi_q;
            BRW_OFF_IO_HI: rd_word = {io_limit_hi_q, io_base_hi_q};
            // fixed pointer to power management block
            BRW_OFF_CAP_PTR: rd_word = {24'h000000, BRW_CAP_PTR};
            // legacy bits come from the masked control copy
            // top four bits are never stored
            BRW_OFF_INT_CTRL: rd_word = {bc_q & BRW_BC_WMASK, int_pin_q, int_line_q};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read data captured with the answer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dat_r_q <= 32'h0000_0000;
        end else if (req_new) begin
            dat_r_q <= wb_req.we ? 32'h0000_0000 : rd_word;
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_r_q;

    // prefetch window upper words
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pf_base_hi_q <= BRW_RST_PF_HI;
            pf_limit_hi_q <= BRW_RST_PF_HI;
        end else if (wr_go) begin
            if (wb_req.adr == BRW_OFF_PF_BASE_HI) begin
                pf_base_hi_q <= lane_merge(pf_base_hi_q, wb_req.dat, wb_req.sel);
            end
            if (wb_req.adr == BRW_OFF_PF_LIMIT_HI) begin
                pf_limit_hi_q <= lane_merge(pf_limit_hi_q, wb_req.dat, wb_req.sel);
            end
        end
    end

    // io window upper halves share one word
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            io_base_hi_q <= BRW_RST_IO_HI;
            io_limit_hi_q <= BRW_RST_IO_HI;
        end else if (wr_go && wb_req.adr == BRW_OFF_IO_HI) begin
            {io_limit_hi_q, io_base_hi_q} <= lane_merge({io_limit_hi_q, io_base_hi_q},
                wb_req.dat, wb_req.sel);
        end
    end

    // interrupt line and forwarding control
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            int_line_q <= BRW_RST_INT_LINE;
            bc_q <= BRW_RST_BC;
        end else if (wr_go && wb_req.adr == BRW_OFF_INT_CTRL) begin
            if (wb_req.sel[0]) begin
                int_line_q <= wb_req.dat[7:0];
            end
            // read-only legacy bits dropped by the mask
            // reserved bits dropped by the mask
            if (wb_req.sel[2]) begin
                bc_q[7:0] <= wb_req.dat[23:16] & BRW_BC_WMASK[7:0];
            end
            if (wb_req.sel[3]) begin
                bc_q[15:8] <= wb_req.dat[31:24] & BRW_BC_WMASK[15:8];
            end
        end
    end

    // interrupt pin: software cannot write it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            int_pin_q <= BRW_RST_INT_PIN;
        end else if (cfg_load_valid && !IS_UPSTREAM) begin
            int_pin_q <= cfg_load_int_pin;
        end
    end

    // named control bits
    // one name per stored bit; bit 21 is masked on write and read,
    // so it always reads back as zero
    logic bc_poison;
    logic secondary_error_forward_en;
    logic legacy_io_alias_en;
    logic bc_disp;
    logic bc_disp16;
    logic bc_sbr;
    assign bc_poison = bc_q[BRW_BC_POISON-16];
    assign secondary_error_forward_en = bc_q[BRW_BC_ERR_FWD-16];
    assign legacy_io_alias_en = bc_q[BRW_BC_ALIAS-16];
    assign bc_disp = bc_q[BRW_BC_DISP-16];
    assign bc_disp16 = bc_q[BRW_BC_DISP16-16];
    assign bc_sbr = bc_q[BRW_BC_SBR-16];

    // assembled window bounds
    logic [63:0] pf_lo;
    logic [63:0] pf_hi;
    logic [63:0] io_lo;
    logic [63:0] io_hi;
    assign pf_lo = {pf_base_hi_q, pf_base_lo, BRW_PF_LO_FILL};
    assign pf_hi = {pf_limit_hi_q, pf_limit_lo, BRW_PF_HI_FILL};
    assign io_lo = {32'h0000_0000, io_base_hi_q, io_base_lo, BRW_IO_LO_FILL};
    assign io_hi = {32'h0000_0000, io_limit_hi_q, io_limit_lo, BRW_IO_HI_FILL};

    // combinational decisions, registered below
    logic io_hit;
    logic io_alias;
    assign io_hit = in_window({32'h0000_0000, io_query.addr}, io_lo, io_hi);
    // limitation: no window test here, io_hit gates the alias where used
    // alias: first 64KB, offset 100h..3ffh in each 1KB block
    assign io_alias = (io_query.addr[31:16] == 16'h0000) && (io_query.addr[9:8] != 2'b00);

    // forwarding decisions, one cycle after the query
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            route <= '0;
        end else begin
            route.mem_valid <= mem_query.valid;
            route.mem_pf_hit <= mem_query.valid && in_window(mem_query.addr, pf_lo, pf_hi);
            // display memory range only while enabled
            route.mem_disp_hit <= mem_query.valid && bc_disp
                && in_window(mem_query.addr, BRW_DISP_MEM_LO, BRW_DISP_MEM_HI);
            route.io_valid <= io_query.valid;
            // clear alias bit forwards the whole window
            route.io_fwd_down <= io_query.valid && io_hit && !(legacy_io_alias_en && io_alias);
            route.io_fwd_up <= io_query.valid && io_hit && legacy_io_alias_en && io_alias;
            // display i/o follows the same enable
            route.io_disp_hit <= io_query.valid && bc_disp && disp_io(io_query.addr, bc_disp16);
        end
    end

    // poisoned packet reporting
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            poison_report <= 1'b0;
        end else begin
            // ignored while the response bit is clear
            poison_report <= poison_seen && bc_poison;
        end
    end

    // error message forwarding to the primary side
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            err_out <= '0;
        end else begin
            err_out.valid <= err_in.valid && secondary_error_forward_en;
            err_out.kind <= err_in.kind;
        end
    end

    // port reset outputs, held while the bit stays set
    // hazard: nothing times the reset out, software must clear the bit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port_rst_b <= '1;
        end else if (IS_UPSTREAM) begin
            // upstream bit resets every downstream port
            port_rst_b <= {NUM_DS_PORTS{!bc_sbr}};
        end else begin
            // downstream bit resets its own device
            port_rst_b <= '1;
            port_rst_b[0] <= !bc_sbr;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_ack_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
        else $error("request not answered in one cycle");
    chk_cap_read: assert property (
        wb_ack && !wb_req.we && wb_req.adr == BRW_OFF_CAP_PTR |-> wb_dat_r == 32'h0000_0040)
        else $error("capability pointer not 40h");
    chk_bc_zero_bits: assert property (
        wb_ack && !wb_req.we && wb_req.adr == BRW_OFF_INT_CTRL
        |-> wb_dat_r[31:28] == 4'h0 && wb_dat_r[27:23] == 5'h00 && !wb_dat_r[21])
        else $error("read-only control bits not zero");
    chk_pf_base_wr: assert property (
        wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack && wb_req.sel == 4'hf
        && wb_req.adr == BRW_OFF_PF_BASE_HI ##1 wb_ack
        |-> pf_base_hi_q == $past(wb_req.dat))
        else $error("prefetch base word not stored");
    chk_io_limit_wr: assert property (
        wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack && wb_req.sel == 4'hc
        && wb_req.adr == BRW_OFF_IO_HI |=> io_limit_hi_q == $past(wb_req.dat[31:16])
        && $stable(io_base_hi_q))
        else $error("io limit half not stored alone");
    chk_poison_gate: assert property (poison_seen |=> poison_report == $past(bc_poison))
        else $error("poison report not gated by control");
    chk_err_gate: assert property (
        err_in.valid && !secondary_error_forward_en |=> !err_out.valid)
        else $error("error message forwarded while disabled");
    chk_disp_mem: assert property (
        mem_query.valid && mem_query.addr == BRW_DISP_MEM_HI
        |=> route.mem_disp_hit == $past(bc_disp))
        else $error("display memory decision wrong");
    chk_alias_up: assert property (
        route.io_fwd_up |-> $past(legacy_io_alias_en) && !route.io_fwd_down)
        else $error("alias forward without enable");
    chk_sbr_reset: assert property ($rose(bc_sbr) |=> !port_rst_b[0] ##1 !port_rst_b[0])
        else $error("port reset not asserted");

    // port reset, pin field, reserved bit and io forwarding checks
    // an upstream port must pull every downstream reset, not just port 0
    chk_ds_rst_all: assert property (IS_UPSTREAM && bc_sbr |=> port_rst_b == '0)
        else $error("downstream ports not all reset");
    // a stuck reset would silently hold the attached device down
    chk_rst_release: assert property (!bc_sbr |=> port_rst_b == '1)
        else $error("port reset held without control bit");
    // loader value lands one edge after its strobe
    chk_pin_load: assert property (
        cfg_load_valid && !IS_UPSTREAM |=> int_pin_q == $past(cfg_load_int_pin))
        else $error("downstream pin value not loaded");
    // upstream keeps its default whatever the loader offers
    chk_pin_up_kept: assert property (
        cfg_load_valid && IS_UPSTREAM |=> $stable(int_pin_q))
        else $error("upstream pin value replaced");
    // software writes to the word must leave the pin byte alone
    chk_pin_ro: assert property (
        wr_go && wb_req.adr == BRW_OFF_INT_CTRL && !cfg_load_valid |=> $stable(int_pin_q))
        else $error("pin field written by software");
    // no stored bit may sit outside the writable mask
    chk_bc_reserved: assert property ((bc_q & ~BRW_BC_WMASK) == 16'h0000)
        else $error("reserved control bits stored");
    // with aliasing off the whole window goes down
    chk_io_down: assert property (
        io_query.valid && !legacy_io_alias_en && io_hit |=> route.io_fwd_down)
        else $error("window io not forwarded down");

    // main scenarios worth seeing in a run
    cov_disp_io: cover property (route.io_disp_hit);
    cov_alias_up: cover property (route.io_fwd_up);
    cov_sbr_cycle: cover property ($rose(bc_sbr) ##[1:20] $fell(bc_sbr));
    cov_pin_load: cover property (cfg_load_valid && !IS_UPSTREAM);
    cov_err_fwd: cover property (err_out.valid);
endmodule
`default_nettype wire

// [dv/brw_far_side.sv]
/*
 * brw_far_side: secondary side traffic source that raises poisoned
 * packet and error message pulses when the bench asks for them.
 * assumes commands change just after a rising edge of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module brw_far_side (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cmd_poison,
    input wire logic cmd_err,
    input wire logic [1:0] cmd_kind,
    output logic poison_seen,
    output brw_pkg::brw_err_msg_t err_in
);
    import brw_pkg::*;

    // one-cycle pulses; idle kind flips so a stale value never passes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            poison_seen <= 1'b0;
            err_in <= '0;
        end else begin
            poison_seen <= cmd_poison;
            err_in.valid <= cmd_err;
            err_in.kind <= cmd_err ? cmd_kind : ~err_in.kind;
        end
    end
endmodule
`default_nettype wire

// [dv/brw_regs_bench.sv]
/*
 * brw_regs_bench: register, event and forwarding tests of brw_regs.
 * assumes default parameters, an upstream copy on the same bus and brw_far_side.
 */
`timescale 1ns/1ps
`default_nettype none
module brw_regs_bench;
    import brw_pkg::*;
    logic clk_sys, rst_b; // 100 MHz clock, active low reset
    brw_wb_req_t wb_req; // bus request, held until ack
    logic [31:0] wb_dat_r, rd; // read data and last sample
    logic [31:0] up_dat_r, rd_up; // upstream copy read data and its sample
    logic wb_ack, cfg_load_valid, poison_seen, poison_report;
    logic [7:0] cfg_load_int_pin;
    logic [11:0] pf_base_lo, pf_limit_lo; // prefetch bits 31..20
    logic [3:0] io_base_lo, io_limit_lo; // io bits 15..12
    brw_mem_query_t mem_query;
    brw_io_query_t io_query;
    brw_route_t route;
    brw_err_msg_t err_in, err_out;
    logic [2:0] port_rst_b, up_port_rst_b;
    logic cmd_poison, cmd_err; // far side commands
    logic [1:0] cmd_kind;
    int miscompares, check_count;

    brw_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .wb_req(wb_req),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .cfg_load_valid(cfg_load_valid),
        .cfg_load_int_pin(cfg_load_int_pin), .pf_base_lo(pf_base_lo),
        .pf_limit_lo(pf_limit_lo), .io_base_lo(io_base_lo), .io_limit_lo(io_limit_lo),
        .mem_query(mem_query), .io_query(io_query), .route(route),
        .poison_seen(poison_seen), .poison_report(poison_report), .err_in(err_in),
        .err_out(err_out), .port_rst_b(port_rst_b));
    brw_far_side far (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_poison(cmd_poison),
        .cmd_err(cmd_err), .cmd_kind(cmd_kind), .poison_seen(poison_seen),
        .err_in(err_in));
    // upstream copy shares every input; only its pin field and resets differ
    brw_regs #(.IS_UPSTREAM(1'b1)) DUT_UP (.clk_sys(clk_sys), .rst_b(rst_b),
        .wb_req(wb_req), .wb_dat_r(up_dat_r), .wb_ack(), .cfg_load_valid(cfg_load_valid),
        .cfg_load_int_pin(cfg_load_int_pin), .pf_base_lo(pf_base_lo),
        .pf_limit_lo(pf_limit_lo), .io_base_lo(io_base_lo), .io_limit_lo(io_limit_lo),
        .mem_query(mem_query), .io_query(io_query), .route(),
        .poison_seen(poison_seen), .poison_report(), .err_in(err_in),
        .err_out(), .port_rst_b(up_port_rst_b));

    // verdict and end of run, shared with the watchdog
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // four-state compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        int n;
        n = 0;
        wb_req <= '{1'b1, 1'b1, we, adr, sel, dat};
        @(posedge clk_sys);
        // no cycle count assumed, only a bound
        while (wb_ack !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 50) begin
            miscompares++;
            $display("BAD t=%0t no ack", $time);
        end
        rd = wb_dat_r;
        rd_up = up_dat_r;
        wb_req <= '0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        wb(1'b1, adr, sel, dat);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 4'hf, 32'h0);
        chk(rd, exp, what);
    endtask

    // memory query; route lands one edge after it is taken
    task automatic mq(input logic [63:0] a, input logic [1:0] exp);
        mem_query <= '{1'b1, a};
        @(posedge clk_sys);
        #1;
        chk({29'h0, route.mem_valid, route.mem_pf_hit, route.mem_disp_hit},
            {29'h0, 1'b1, exp}, "mem route");
        @(posedge clk_sys);
    endtask

    // io query; expected down, up, display
    task automatic iq(input logic [31:0] a, input logic [2:0] exp);
        io_query <= '{1'b1, a};
        @(posedge clk_sys);
        #1;
        chk({28'h0, route.io_valid, route.io_fwd_down, route.io_fwd_up, route.io_disp_hit},
            {28'h0, 1'b1, exp}, "io route");
        @(posedge clk_sys);
    endtask

    // poison and error pulse through the far side
    task automatic evt(input logic [1:0] k, input logic exp_p, input logic exp_e);
        cmd_poison <= 1'b1;
        cmd_err <= 1'b1;
        cmd_kind <= k;
        @(posedge clk_sys);
        cmd_poison <= 1'b0;
        cmd_err <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({28'h0, poison_report, err_out.valid, exp_e ? err_out.kind : 2'b00},
            {28'h0, exp_p, exp_e, exp_e ? k : 2'b00}, "event out");
        @(posedge clk_sys);
    endtask

    // free-running clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        $display("BAD t=%0t watchdog expired", $time);
        results();
    end

    initial begin
        rst_b = 1'b0;
        wb_req = '0;
        {cfg_load_valid, cfg_load_int_pin, cmd_poison, cmd_err, cmd_kind} = '0;
        mem_query = '0;
        io_query = '0;
        pf_base_lo = 12'h001;
        pf_limit_lo = 12'h002;
        io_base_lo = 4'h1;
        io_limit_lo = 4'h2;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // reset values, unmapped place reads zero
        rdc(BRW_OFF_PF_BASE_HI, 32'h0, "pf base rst");
        rdc(BRW_OFF_PF_LIMIT_HI, 32'h0, "pf limit rst");
        rdc(BRW_OFF_IO_HI, 32'h0, "io rst");
        rdc(BRW_OFF_CAP_PTR, 32'h0000_0040, "cap ptr");
        rdc(BRW_OFF_INT_CTRL, 32'h0, "int ctrl rst");
        rdc(8'h20, 32'h0, "unmapped");
        chk({29'h0, port_rst_b}, 32'h7, "port rst idle");
        chk({29'h0, up_port_rst_b}, 32'h7, "all ports idle");
        $display("test reset done");
        // writes, byte lanes, read-only and reserved bits
        wr(BRW_OFF_PF_BASE_HI, 4'hf, 32'h0000_0001);
        wr(BRW_OFF_PF_LIMIT_HI, 4'hf, 32'h0000_0001);
        wr(BRW_OFF_IO_HI, 4'hf, 32'ha5a5_5a5a);
        wr(BRW_OFF_IO_HI, 4'h6, 32'h1234_5678);
        rdc(BRW_OFF_IO_HI, 32'ha534_565a, "io halves");
        wr(BRW_OFF_IO_HI, 4'hc, 32'h1357_ffff);
        rdc(BRW_OFF_IO_HI, 32'h1357_565a, "io limit alone");
        wr(BRW_OFF_CAP_PTR, 4'hf, 32'hffff_ffff);
        rdc(BRW_OFF_CAP_PTR, 32'h0000_0040, "cap ptr ro");
        wr(8'h20, 4'hf, 32'hffff_ffff);
        rdc(BRW_OFF_PF_BASE_HI, 32'h0000_0001, "pf base");
        rdc(BRW_OFF_PF_LIMIT_HI, 32'h0000_0001, "pf limit");
        wr(BRW_OFF_INT_CTRL, 4'hf, 32'hffff_ffff);
        rdc(BRW_OFF_INT_CTRL, 32'h005f_00ff, "ctrl mask");
        chk({29'h0, port_rst_b}, 32'h6, "port rst on");
        chk({29'h0, up_port_rst_b}, 32'h0, "all ports rst on");
        wr(BRW_OFF_INT_CTRL, 4'hc, 32'h0);
        chk({29'h0, port_rst_b}, 32'h7, "port rst off");
        chk({29'h0, up_port_rst_b}, 32'h7, "all ports rst off");
        wr(BRW_OFF_IO_HI, 4'hf, 32'h0);
        $display("test registers done");
        // configuration load of the pin field
        cfg_load_int_pin <= 8'h01;
        cfg_load_valid <= 1'b1;
        @(posedge clk_sys);
        cfg_load_valid <= 1'b0;
        @(posedge clk_sys);
        rdc(BRW_OFF_INT_CTRL, 32'h0000_01ff, "pin load");
        chk(rd_up, 32'h0000_00ff, "upstream pin kept");
        $display("test load done");
        // poison and error gating, all four settings
        evt(2'h1, 1'b0, 1'b0);
        wr(BRW_OFF_INT_CTRL, 4'h4, 32'h0001_0000);
        evt(2'h2, 1'b1, 1'b0);
        wr(BRW_OFF_INT_CTRL, 4'h4, 32'h0002_0000);
        evt(2'h3, 1'b0, 1'b1);
        wr(BRW_OFF_INT_CTRL, 4'h4, 32'h0003_0000);
        evt(2'h0, 1'b1, 1'b1);
        $display("test events done");
        // prefetch window edges and display memory range
        mq(64'h0000_0001_0010_0000, 2'b10);
        mq(64'h0000_0001_002f_ffff, 2'b10);
        mq(64'h0000_0001_000f_ffff, 2'b00);
        mq(64'h0000_0001_0030_0000, 2'b00);
        mq(64'h0000_0000_000a_0000, 2'b00);
        wr(BRW_OFF_INT_CTRL, 4'h4, 32'h0008_0000);
        mq(64'h0000_0000_000a_0000, 2'b01);
        mq(64'h0000_0000_000b_ffff, 2'b01);
        mq(64'h0000_0000_0009_ffff, 2'b00);
        mq(64'h0000_0000_000c_0000, 2'b00);
        mem_query <= '0;
        $display("test memory done");
        // io window, alias and display decode
        iq(32'h0000_1000, 3'b100);
        iq(32'h0000_2fff, 3'b100);
        iq(32'h0000_3000, 3'b000);
        iq(32'h0000_03b0, 3'b001);
        iq(32'h0000_13c0, 3'b101);
        iq(32'h0000_03e0, 3'b000);
        iq(32'h0001_03b0, 3'b000);
        wr(BRW_OFF_INT_CTRL, 4'h4, 32'h001c_0000);
        iq(32'h0000_13c0, 3'b010);
        iq(32'h0000_1000, 3'b100);
        iq(32'h0000_03df, 3'b001);
        io_query <= '0;
        $display("test io done");
        results();
    end
endmodule
`default_nettype wire
